// File: psif_regs.vh
// psif_regs.vh: register indices, reset values, limits and field positions
// assumes apb byte address = 4 * index, 16-bit registers in the low data bits except the 32-bit pulse frequency
`ifndef PSIF_REGS_VH
`define PSIF_REGS_VH

`define PSIF_IDX_ENC_TYPE 12'h a00
`define PSIF_IDX_PPR 12'h a01
`define PSIF_IDX_FB_TYPE 12'h a02
`define PSIF_IDX_GEAR_L1 12'h a04
`define PSIF_IDX_GEAR_M1 12'h a05
`define PSIF_IDX_GEAR_L2 12'h a06
`define PSIF_IDX_GEAR_M2 12'h a07
`define PSIF_IDX_STALL_LVL 12'h a0a
`define PSIF_IDX_STALL_TIME 12'h a0b
`define PSIF_IDX_STALL_ACT 12'h a0c
`define PSIF_IDX_SLIP_RANGE 12'h a0d
`define PSIF_IDX_SLIP_TIME 12'h a0e
`define PSIF_IDX_ERR_ACT 12'h a0f
`define PSIF_IDX_REF_TYPE 12'h a10
`define PSIF_IDX_REF_GEAR_A 12'h a11
`define PSIF_IDX_REF_GEAR_B 12'h a12
`define PSIF_IDX_STATUS 12'h a20
`define PSIF_IDX_PULSE_FREQ 12'h a21
`define PSIF_IDX_ROT_SPEED 12'h a22

`define PSIF_RST_PPR 16'h 0258
`define PSIF_RST_GEAR 16'h 0064
`define PSIF_RST_STALL_LVL 16'h 0073
`define PSIF_RST_STALL_TIME 16'h 0001
`define PSIF_RST_SLIP_RANGE 16'h 0032
`define PSIF_RST_SLIP_TIME 16'h 0005
`define PSIF_RST_ACTION 16'h 0002
`define PSIF_RST_OFF 16'h 0000

`define PSIF_PPR_MAX 16'h 4e20
`define PSIF_STALL_LVL_MAX 16'h 0078
`define PSIF_STALL_TIME_MAX 16'h 0014
`define PSIF_SLIP_RANGE_MAX 16'h 0032
`define PSIF_SLIP_TIME_MAX 16'h 0064
`define PSIF_ACTION_MAX 16'h 0002
`define PSIF_TYPE_OFF 16'h 0000
`define PSIF_TYPE_PULSE 16'h 0005

`define PSIF_ACT_WARN 16'h 0000
`define PSIF_ACT_RAMP 16'h 0001
`define PSIF_ACT_COAST 16'h 0002

`define PSIF_ST_STALL 0
`define PSIF_ST_SLIP 1
`define PSIF_ST_GEAR2 2
`define PSIF_ST_FB_ON 3
`define PSIF_ST_REF_ON 4

`define PSIF_PCT 8'h 64
`define PSIF_CLK_MHZ 250
`define PSIF_TICK_US 100000
`define PSIF_FREQ_SCALE 100

`endif

// File: psif_pulse_speed.v
// psif_pulse_speed.v: single-phase pulse input used as encoder speed feedback
// or as pulse-frequency reference, with encoder stall and slip supervision.
// assumes pulse_input_pin and gear_select_pin are asynchronous pins; the
// frequency ports come from drive logic on pclk, in units of 0.01 Hz.
`timescale 1ns/1ps
`include "psif_regs.vh"

module psif_pulse_speed #(
	parameter TICK_CYCLES = `PSIF_TICK_US * `PSIF_CLK_MHZ,
	parameter PERIOD_MAX = 24'h ffffff,
	parameter [47:0] CLK_SCALED = 48'h 0005_d21d_ba00
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire pulse_input_pin,
	input wire gear_select_pin,
	input wire closed_loop_vf_encoder_mode,
	input wire [15:0] max_operating_frequency,
	input wire [15:0] output_frequency,
	input wire [15:0] motor_frequency,
	output reg [15:0] feedback_speed_q,
	output reg [15:0] reference_freq_q,
	output reg stall_warn_q,
	output reg slip_warn_q,
	output reg fault_ramp_stop_q,
	output reg fault_coast_stop_q
);
	localparam S_IDLE = 2'b00;
	localparam S_FREQ = 2'b01;
	localparam S_SPEED = 2'b10;
	localparam S_LOAD = 2'b11;
	localparam [5:0] DIV_STEPS = 6'd47;

	reg [15:0] enc_type_q, ppr_q, fb_type_q, gl1_q, gm1_q, gl2_q, gm2_q;
	reg [15:0] stall_lvl_q, stall_time_q, stall_act_q, slip_rng_q, slip_time_q, err_act_q;
	reg [15:0] ref_type_q, ref_a_q, ref_b_q;
	reg stall_err_q, slip_err_q;
	reg pin_s1_q, pin_s2_q, pin_s3_q, gsel_s1_q, gsel_s2_q;
	reg [23:0] period_cnt_q;
	reg [31:0] pulse_freq_q;
	reg [15:0] speed_q;
	reg [1:0] state_q;
	reg [5:0] step_q;
	reg [47:0] num_q;
	reg [31:0] den_q;
	reg [32:0] rem_q;
	reg [31:0] tick_cnt_q;
	reg [7:0] stall_tmr_q, slip_tmr_q;

	wire idx_ok = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);
	wire [11:0] idx = paddr[13:2];
	wire wr_en = psel && penable && pwrite;
	wire [15:0] wv = pwdata[15:0];
	wire wv_hi_zero = (pwdata[31:16] == 16'h0000);
	wire gear_ok = wv_hi_zero && (wv != 16'h0000);
	wire type_ok = wv_hi_zero && ((wv == `PSIF_TYPE_OFF) || (wv == `PSIF_TYPE_PULSE));
	wire act_ok = wv_hi_zero && (wv <= `PSIF_ACTION_MAX);
	reg mapped;

	wire fb_on = (enc_type_q == `PSIF_TYPE_PULSE) && (fb_type_q == `PSIF_TYPE_PULSE) &&
		(ref_type_q == `PSIF_TYPE_OFF) && closed_loop_vf_encoder_mode;
	wire ref_on = (enc_type_q == `PSIF_TYPE_PULSE) && (ref_type_q == `PSIF_TYPE_PULSE);
	wire [15:0] fb_a = gsel_s2_q ? gl2_q : gl1_q;
	wire [15:0] fb_b = gsel_s2_q ? gm2_q : gm1_q;
	wire [15:0] gear_a = ref_on ? ref_a_q : fb_a;
	wire [15:0] gear_b = ref_on ? ref_b_q : fb_b;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always @* begin
		mapped = idx_ok;
		prdata = 32'h 0000_0000;
		case (idx)
		`PSIF_IDX_ENC_TYPE: prdata[15:0] = enc_type_q;
		`PSIF_IDX_PPR: prdata[15:0] = ppr_q;
		`PSIF_IDX_FB_TYPE: prdata[15:0] = fb_type_q;
		`PSIF_IDX_GEAR_L1: prdata[15:0] = gl1_q;
		`PSIF_IDX_GEAR_M1: prdata[15:0] = gm1_q;
		`PSIF_IDX_GEAR_L2: prdata[15:0] = gl2_q;
		`PSIF_IDX_GEAR_M2: prdata[15:0] = gm2_q;
		`PSIF_IDX_STALL_LVL: prdata[15:0] = stall_lvl_q;
		`PSIF_IDX_STALL_TIME: prdata[15:0] = stall_time_q;
		`PSIF_IDX_STALL_ACT: prdata[15:0] = stall_act_q;
		`PSIF_IDX_SLIP_RANGE: prdata[15:0] = slip_rng_q;
		`PSIF_IDX_SLIP_TIME: prdata[15:0] = slip_time_q;
		`PSIF_IDX_ERR_ACT: prdata[15:0] = err_act_q;
		`PSIF_IDX_REF_TYPE: prdata[15:0] = ref_type_q;
		`PSIF_IDX_REF_GEAR_A: prdata[15:0] = ref_a_q;
		`PSIF_IDX_REF_GEAR_B: prdata[15:0] = ref_b_q;
		`PSIF_IDX_STATUS: begin
			prdata[`PSIF_ST_STALL] = stall_err_q;
			prdata[`PSIF_ST_SLIP] = slip_err_q;
			prdata[`PSIF_ST_GEAR2] = gsel_s2_q;
			prdata[`PSIF_ST_FB_ON] = fb_on;
			prdata[`PSIF_ST_REF_ON] = ref_on;
		end
		`PSIF_IDX_PULSE_FREQ: prdata = pulse_freq_q;
		`PSIF_IDX_ROT_SPEED: prdata[15:0] = speed_q;
		default: mapped = 1'b0;
		endcase
		if (!idx_ok) begin
			prdata = 32'h 0000_0000;
		end
	end

	// out-of-range writes are dropped so the stored setting is always legal
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_type_q <= `PSIF_RST_OFF;
			ppr_q <= `PSIF_RST_PPR;
			fb_type_q <= `PSIF_RST_OFF;
			gl1_q <= `PSIF_RST_GEAR;
			gm1_q <= `PSIF_RST_GEAR;
			gl2_q <= `PSIF_RST_GEAR;
			gm2_q <= `PSIF_RST_GEAR;
			stall_lvl_q <= `PSIF_RST_STALL_LVL;
			stall_time_q <= `PSIF_RST_STALL_TIME;
			stall_act_q <= `PSIF_RST_ACTION;
			slip_rng_q <= `PSIF_RST_SLIP_RANGE;
			slip_time_q <= `PSIF_RST_SLIP_TIME;
			err_act_q <= `PSIF_RST_ACTION;
			ref_type_q <= `PSIF_RST_OFF;
			ref_a_q <= `PSIF_RST_GEAR;
			ref_b_q <= `PSIF_RST_GEAR;
		end else if (wr_en && idx_ok) begin
			case (idx)
			`PSIF_IDX_ENC_TYPE: if (type_ok) enc_type_q <= wv;
			`PSIF_IDX_PPR: if (gear_ok && wv <= `PSIF_PPR_MAX) ppr_q <= wv;
			`PSIF_IDX_FB_TYPE: if (type_ok && !(wv == `PSIF_TYPE_PULSE && ref_type_q == `PSIF_TYPE_PULSE))
				fb_type_q <= wv;
			`PSIF_IDX_GEAR_L1: if (gear_ok) gl1_q <= wv;
			`PSIF_IDX_GEAR_M1: if (gear_ok) gm1_q <= wv;
			`PSIF_IDX_GEAR_L2: if (gear_ok) gl2_q <= wv;
			`PSIF_IDX_GEAR_M2: if (gear_ok) gm2_q <= wv;
			`PSIF_IDX_STALL_LVL: if (wv_hi_zero && wv <= `PSIF_STALL_LVL_MAX) stall_lvl_q <= wv;
			`PSIF_IDX_STALL_TIME: if (wv_hi_zero && wv <= `PSIF_STALL_TIME_MAX) stall_time_q <= wv;
			`PSIF_IDX_STALL_ACT: if (act_ok) stall_act_q <= wv;
			`PSIF_IDX_SLIP_RANGE: if (wv_hi_zero && wv <= `PSIF_SLIP_RANGE_MAX) slip_rng_q <= wv;
			`PSIF_IDX_SLIP_TIME: if (wv_hi_zero && wv <= `PSIF_SLIP_TIME_MAX) slip_time_q <= wv;
			`PSIF_IDX_ERR_ACT: if (act_ok) err_act_q <= wv;
			`PSIF_IDX_REF_TYPE: if (type_ok) ref_type_q <= wv;
			`PSIF_IDX_REF_GEAR_A: if (gear_ok) ref_a_q <= wv;
			`PSIF_IDX_REF_GEAR_B: if (gear_ok) ref_b_q <= wv;
			default: ;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
			gsel_s1_q <= 1'b0;
			gsel_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= pulse_input_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			gsel_s1_q <= gear_select_pin;
			gsel_s2_q <= gsel_s1_q;
		end
	end

	wire pin_rise = pin_s2_q && !pin_s3_q;
	wire period_tmo = (period_cnt_q == PERIOD_MAX);
	wire [32:0] trial = {rem_q[31:0], num_q[47]};
	wire fits = (trial >= {1'b0, den_q});
	wire [47:0] spd_num = pulse_freq_q * gear_a;
	wire [31:0] spd_den = ppr_q * gear_b;
	// quotient is {num_q[46:0], fits} on the last step; saturate rather than wrap past 16 bits
	wire [15:0] spd_sat = (num_q[46:15] != 32'h 0000_0000) ? 16'h ffff : {num_q[14:0], fits};

	// edge interval measured, then two serial divisions
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt_q <= 24'h 000000;
			pulse_freq_q <= 32'h 0000_0000;
			speed_q <= 16'h 0000;
			state_q <= S_IDLE;
			step_q <= 6'h 00;
			num_q <= 48'h 0;
			den_q <= 32'h 0;
			rem_q <= 33'h 0;
		end else begin
			if (pin_rise || period_tmo) begin
				period_cnt_q <= 24'h 000001;
			end else begin
				period_cnt_q <= period_cnt_q + 24'h 000001;
			end
			case (state_q)
			S_IDLE: begin
				if (period_tmo) begin
					pulse_freq_q <= 32'h 0000_0000;
					speed_q <= 16'h 0000;
				end else if (pin_rise && period_cnt_q != 24'h 000000) begin
					num_q <= CLK_SCALED;
					den_q <= {8'h 00, period_cnt_q};
					rem_q <= 33'h 0;
					step_q <= 6'h 00;
					state_q <= S_FREQ;
				end
			end
			S_FREQ, S_SPEED: begin
				num_q <= {num_q[46:0], fits};
				rem_q <= fits ? (trial - {1'b0, den_q}) : trial;
				step_q <= step_q + 6'h 01;
				if (step_q == DIV_STEPS) begin
					step_q <= 6'h 00;
					rem_q <= 33'h 0;
					if (state_q == S_FREQ) begin
						pulse_freq_q <= (num_q[46:31] == 16'h 0000) ? {num_q[30:0], fits} : 32'h ffff_ffff;
						state_q <= S_LOAD;
					end else begin
						speed_q <= spd_sat;
						state_q <= S_IDLE;
					end
				end
			end
			// speed operands: rate times gear A over ppr times gear B
			// a rise seen while dividing is not measured; the period count still restarts
			S_LOAD: begin
				num_q <= spd_num;
				den_q <= spd_den;
				rem_q <= 33'h 0;
				step_q <= 6'h 00;
				state_q <= S_SPEED;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

	// supervision: 0.1 s tick and per-check tick counters
	wire tick = (tick_cnt_q == TICK_CYCLES - 1);
	wire [31:0] out_pct = output_frequency * `PSIF_PCT;
	wire [31:0] stall_lim = max_operating_frequency * stall_lvl_q;
	wire [15:0] slip_diff = (speed_q > motor_frequency) ? speed_q - motor_frequency : motor_frequency - speed_q;
	wire [31:0] slip_pct = slip_diff * `PSIF_PCT;
	wire [31:0] slip_lim = max_operating_frequency * slip_rng_q;
	wire stall_cond = fb_on && (stall_lvl_q != 16'h 0000) && (out_pct > stall_lim);
	wire slip_cond = fb_on && (slip_rng_q != 16'h 0000) && (slip_pct > slip_lim);
	wire stall_trip = stall_cond && ({8'h 00, stall_tmr_q} > stall_time_q);
	wire slip_trip = slip_cond && ({8'h 00, slip_tmr_q} > slip_time_q);
	wire st_wr = wr_en && idx_ok && (idx == `PSIF_IDX_STATUS);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h 0000_0000;
			stall_tmr_q <= 8'h 00;
			slip_tmr_q <= 8'h 00;
			stall_err_q <= 1'b0;
			slip_err_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick ? 32'h 0000_0000 : tick_cnt_q + 32'h 0000_0001;
			if (!stall_cond) begin
				stall_tmr_q <= 8'h 00;
			end else if (tick && stall_tmr_q != 8'h ff) begin
				stall_tmr_q <= stall_tmr_q + 8'h 01;
			end
			if (!slip_cond) begin
				slip_tmr_q <= 8'h 00;
			end else if (tick && slip_tmr_q != 8'h ff) begin
				slip_tmr_q <= slip_tmr_q + 8'h 01;
			end
			// a trip in the clearing cycle wins over the write-one-to-clear
			stall_err_q <= stall_trip || (stall_err_q && !(st_wr && pwdata[`PSIF_ST_STALL]));
			slip_err_q <= slip_trip || (slip_err_q && !(st_wr && pwdata[`PSIF_ST_SLIP]));
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_warn_q <= 1'b0;
			slip_warn_q <= 1'b0;
			fault_ramp_stop_q <= 1'b0;
			fault_coast_stop_q <= 1'b0;
			feedback_speed_q <= 16'h 0000;
			reference_freq_q <= 16'h 0000;
		end else begin
			stall_warn_q <= stall_err_q && (stall_act_q == `PSIF_ACT_WARN);
			slip_warn_q <= slip_err_q && (err_act_q == `PSIF_ACT_WARN);
			fault_ramp_stop_q <= (stall_err_q && stall_act_q == `PSIF_ACT_RAMP) ||
				(slip_err_q && err_act_q == `PSIF_ACT_RAMP);
			fault_coast_stop_q <= (stall_err_q && stall_act_q == `PSIF_ACT_COAST) ||
				(slip_err_q && err_act_q == `PSIF_ACT_COAST);
			feedback_speed_q <= fb_on ? speed_q : 16'h 0000;
			reference_freq_q <= ref_on ? speed_q : 16'h 0000;
		end
	end

endmodule // psif_pulse_speed

// File: psif_pulse_speed_chk.sv
// psif_pulse_speed_chk.sv: port-level assertions for the pulse speed block
// assumes a single pclk domain; bound into every psif_pulse_speed instance
`timescale 1ns/1ps
module psif_pulse_speed_chk #(
	parameter PERIOD_MAX = 24'hffffff
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire pulse_input_pin,
	input wire gear_select_pin,
	input wire closed_loop_vf_encoder_mode,
	input wire [15:0] max_operating_frequency,
	input wire [15:0] output_frequency,
	input wire [15:0] motor_frequency,
	input wire [15:0] feedback_speed_q,
	input wire [15:0] reference_freq_q,
	input wire stall_warn_q,
	input wire slip_warn_q,
	input wire fault_ramp_stop_q,
	input wire fault_coast_stop_q
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// cycles since the pin last moved; saturates so it never wraps back to zero
	reg [24:0] idle_q;
	reg pin_q;
	wire [24:0] idle_d = (pulse_input_pin != pin_q) ? 25'h0 : idle_q + {24'h0, ~idle_q[24]};
	wire wr_acc = psel && penable && pwrite;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q <= 25'h0;
			pin_q <= 1'b0;
		end else begin
			idle_q <= idle_d;
			pin_q <= pulse_input_pin;
		end
	end
	zero_wait_a: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	err_access_a: assert property (pslverr |-> psel && penable)
		else $error("error flag outside access phase");
	rdata_upper_a: assert property (psel && penable && !pwrite && !pslverr |-> prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	// margin covers sync, divide and speed latency after the period limit
	idle_speed_a: assert property (idle_q > PERIOD_MAX + 200 |-> feedback_speed_q == 16'h0000 && reference_freq_q == 16'h0000)
		else $error("speed held without pulses");
	fb_mode_a: assert property (!closed_loop_vf_encoder_mode [*3] |-> feedback_speed_q == 16'h0000)
		else $error("feedback speed outside encoder mode");
	role_excl_a: assert property (!(feedback_speed_q != 16'h0000 && reference_freq_q != 16'h0000))
		else $error("pulse input used in both roles");
	warn_fall_a: assert property ($fell(stall_warn_q || slip_warn_q) |-> $past(wr_acc, 2) || $past(wr_acc))
		else $error("warning dropped without a write");
	fault_fall_a: assert property ($fell(fault_ramp_stop_q || fault_coast_stop_q) |-> $past(wr_acc, 2) || $past(wr_acc))
		else $error("fault dropped without a write");
	cover property (stall_warn_q);
	cover property (slip_warn_q);
	cover property (fault_coast_stop_q);
endmodule // psif_pulse_speed_chk

bind psif_pulse_speed psif_pulse_speed_chk #(.PERIOD_MAX(PERIOD_MAX)) psif_pulse_speed_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_input_pin(pulse_input_pin),
	.gear_select_pin(gear_select_pin), .closed_loop_vf_encoder_mode(closed_loop_vf_encoder_mode),
	.max_operating_frequency(max_operating_frequency), .output_frequency(output_frequency),
	.motor_frequency(motor_frequency), .feedback_speed_q(feedback_speed_q), .reference_freq_q(reference_freq_q),
	.stall_warn_q(stall_warn_q), .slip_warn_q(slip_warn_q), .fault_ramp_stop_q(fault_ramp_stop_q),
	.fault_coast_stop_q(fault_coast_stop_q));

// File: psif_pulse_src.sv
// psif_pulse_src.sv: behavioural single-phase pulse source for the input pin
// assumes the bench gives run and the half period; the pin rests low when stopped
`timescale 1ns/1ps
module psif_pulse_src #(
	parameter MIN_HALF_NS = 40
) (
	input wire run,
	input wire [31:0] half_ns,
	output logic pin
);
	initial begin
		pin = 1'b0;
		forever begin
			wait (run);
			// start off the clock grid so no pin edge races a sampling edge
			#1;
			while (run) begin
				// rate ceiling, in the bench's scaled time base
				#((half_ns < MIN_HALF_NS) ? MIN_HALF_NS : half_ns) pin = 1'b1;
				#((half_ns < MIN_HALF_NS) ? MIN_HALF_NS : half_ns) pin = 1'b0;
			end
		end
	end
endmodule // psif_pulse_src

// File: psif_pulse_speed_tb.sv
// psif_pulse_speed_tb.sv: self-checking bench for the pulse speed block
// assumes a shortened tick and frequency scale so the run stays short
`timescale 1ns/1ps
module psif_pulse_speed_tb;
	logic pclk, presetn, psel, penable, pwrite, gear_sel, mode, run;
	logic [15:0] paddr, max_f, out_f, mot_f, fb_spd, ref_f;
	logic [31:0] pwdata, prdata;
	logic [31:0] half = 32'hc8;
	logic pready, pslverr, pin, sw, lw, fr, fc;
	logic [33:0] expq[$];
	logic [11:0] ix[16] = '{12'ha00, 12'ha01, 12'ha02, 12'ha04, 12'ha05, 12'ha06, 12'ha07, 12'ha0a,
		12'ha0b, 12'ha0c, 12'ha0d, 12'ha0e, 12'ha0f, 12'ha10, 12'ha11, 12'ha12};
	logic [15:0] rv[16] = '{16'h0, 16'h258, 16'h0, 16'h64, 16'h64, 16'h64, 16'h64, 16'h73,
		16'h1, 16'h2, 16'h32, 16'h5, 16'h2, 16'h0, 16'h64, 16'h64};
	logic [15:0] bad[16] = '{16'h3, 16'h4e21, 16'h3, 16'h0, 16'h0, 16'h0, 16'h0, 16'h79,
		16'h15, 16'h3, 16'h33, 16'h65, 16'h3, 16'h3, 16'h0, 16'h0};
	logic [15:0] top[16] = '{16'h5, 16'h4e20, 16'h5, 16'hffff, 16'h1, 16'hffff, 16'h1, 16'h78,
		16'h14, 16'h2, 16'h32, 16'h64, 16'h2, 16'h0, 16'h1, 16'hffff};
	logic [3:0] act;
	wire [35:0] obs = {sw, lw, fr, fc, ref_f, fb_spd};
	int err_total, n_compared, i;
	// scale 1e6: a 100-cycle period reads as 10000 in frequency units
	psif_pulse_speed #(.TICK_CYCLES(50), .PERIOD_MAX(24'h000400), .CLK_SCALED(48'h0000_000f_4240)) psif_pulse_speed_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_input_pin(pin),
		.gear_select_pin(gear_sel), .closed_loop_vf_encoder_mode(mode), .max_operating_frequency(max_f),
		.output_frequency(out_f), .motor_frequency(mot_f), .feedback_speed_q(fb_spd), .reference_freq_q(ref_f),
		.stall_warn_q(sw), .slip_warn_q(lw), .fault_ramp_stop_q(fr), .fault_coast_stop_q(fc));
	psif_pulse_src psif_pulse_src_inst (.run(run), .half_ns(half), .pin(pin));
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// kind bit 1: compare read data, bit 0: expected error flag
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] d, input logic [1:0] kind,
		input logic [15:0] exp);
		int n;
		expq.push_back({kind, 16'h0000, exp});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d, 2'b00, 16'h0000);
	endtask
	task automatic rd(input logic [11:0] idx, input logic [15:0] exp);
		bus(1'b0, idx, 32'h0, 2'b10, exp);
	endtask
	task automatic wait_obs(input string what, input logic [35:0] mask, input logic [35:0] val);
		int n;
		n = 0;
		while ((obs & mask) !== val && n < 3000) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk(what, val, obs & mask);
	endtask
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		report_and_stop();
	end
	always @(posedge pclk) begin
		logic [33:0] e;
		if (psel && penable && pready === 1'b1) begin
			e = expq.pop_front();
			chk("pslverr", e[32], pslverr);
			if (e[33]) chk("prdata", e[31:0], prdata);
		end
	end
	initial begin
		{psel, penable, pwrite, gear_sel, mode, run} = 6'h00;
		{paddr, pwdata, out_f, mot_f} = 80'h0;
		max_f = 16'h2710;
		presetn = 1'b0;
		err_total = 0;
		n_compared = 0;
		void'($urandom(32'ha49d9361));
		bad[1] = 16'h4e21 + 16'($urandom_range(999));
		top[4] = 16'($urandom_range(65535, 1));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// reset value, refused out-of-range write, then an accepted value, a limit except the random one for a05
		for (i = 0; i < 16; i++) begin
			rd(ix[i], rv[i]);
			wr(ix[i], {16'h0000, bad[i]});
			rd(ix[i], rv[i]);
			wr(ix[i], {16'h0000, top[i]});
			rd(ix[i], top[i]);
		end
		bus(1'b0, 12'ha03, 32'h0, 2'b01, 16'h0000);
		wr(12'ha01, 32'h0001_000a);
		rd(12'ha01, 16'h4e20);
		wr(12'ha02, 32'h0);
		wr(12'ha01, 32'ha);
		wr(12'ha11, 32'h3);
		wr(12'ha12, 32'h2);
		wr(12'ha10, 32'h5);
		wr(12'ha02, 32'h5);
		rd(12'ha02, 16'h0000);
		run <= 1'b1;
		wait_obs("reference_freq_q", 36'h0_ffff_ffff, 36'h0_05dc_0000);
		rd(12'ha21, 16'h2710);
		wr(12'ha10, 32'h0);
		wr(12'ha02, 32'h5);
		wr(12'ha04, 32'h64);
		wr(12'ha05, 32'h64);
		wr(12'ha06, 32'h3);
		wr(12'ha07, 32'h2);
		wr(12'ha0a, 32'h0);
		wr(12'ha0d, 32'h0);
		mode <= 1'b1;
		wait_obs("feedback_speed_q", 36'h0_ffff_ffff, 36'h0_0000_03e8);
		gear_sel <= 1'b1;
		wait_obs("feedback_speed_q", 36'hffff, 36'h05dc);
		rd(12'ha22, 16'h05dc);
		mode <= 1'b0;
		wait_obs("feedback_speed_q", 36'hffff, 36'h0000);
		mode <= 1'b1;
		wait_obs("feedback_speed_q", 36'hffff, 36'h05dc);
		wr(12'ha0a, 32'h73);
		wr(12'ha0b, 32'h1);
		for (i = 0; i < 3; i++) begin
			act = 4'h8 >> (i + (i > 0));
			wr(12'ha0c, 32'(i));
			out_f <= 16'h2d50;
			wait_obs("stall action", 36'hf_0000_0000, {act, 32'h0});
			out_f <= 16'h2cec;
			wr(12'ha20, 32'h1);
			wait_obs("stall clear", 36'hf_0000_0000, 36'h0);
		end
		// at exactly the level the timer must stay idle past the detection time
		repeat (300) @(posedge pclk);
		chk("stall at level", 4'h0, obs[35:32]);
		wr(12'ha0a, 32'h0);
		wr(12'ha0e, 32'h5);
		wr(12'ha0f, 32'h0);
		wr(12'ha0d, 32'h5);
		wait_obs("slip warn", 36'hf_0000_0000, 36'h4_0000_0000);
		mot_f <= 16'h05dc;
		wr(12'ha20, 32'h2);
		wait_obs("slip clear", 36'hf_0000_0000, 36'h0);
		run <= 1'b0;
		wait_obs("idle speed", 36'hffff, 36'h0000);
		rd(12'ha21, 16'h0000);
		report_and_stop();
	end
endmodule // psif_pulse_speed_tb
